// ---- verilog/irq_book_pkg.sv ----
// Register map, field layout and carrier types of the interrupt bookkeeping block
package irq_book_pkg;
   localparam int NUM_SRC = 17;
   // Register byte addresses
   localparam logic [31:0] ENABLE_SET_ADDR = 32'hE000E100;
   localparam logic [31:0] ENABLE_CLEAR_ADDR = 32'hE000E180;
   localparam logic [31:0] PENDING_SET_ADDR = 32'hE000E200;
   localparam logic [31:0] PENDING_CLEAR_ADDR = 32'hE000E280;
   localparam logic [31:0] ACTIVE_ADDR = 32'hE000E300;
   localparam logic [31:0] MISSED_ADDR = 32'h4000A820;
   localparam logic [31:0] IRQ_STATUS_ADDR = 32'h4000A840;
   localparam logic [31:0] IRQ_MASK_ADDR = 32'h4000A844;
   localparam logic [31:0] AUX_FAULT_ADDR = 32'hE000ED3C;
   // Source vector layout
   localparam int SRC_EXT_PIN_LO = 12;
   localparam int SRC_DEBUG = 16;
   localparam int EXT_PINS = 4;
   localparam logic [16:0] MISSED_MASK = 17'h0FFFC;
   // Auxiliary fault field positions
   localparam int AUX_FAULT_BITS = 4;
   localparam int FAULT_WIDTH_BIT = 3;
   localparam int FAULT_PRIV_BIT = 2;
   localparam int FAULT_UNIMPL_BIT = 1;
   localparam int FAULT_OVERFLOW_BIT = 0;
   // Interrupt status and mask layout
   localparam int IST_BITS = 2;
   localparam int IST_FAULT_BIT = 0;
   localparam int IST_MISSED_BIT = 1;
   // Reset values
   localparam logic [16:0] SRC_VEC_RST = 17'h00000;
   localparam logic [AUX_FAULT_BITS-1:0] AUX_FAULT_RST = 4'h0;
   localparam logic [IST_BITS-1:0] IST_RST = 2'h0;
   localparam logic [31:0] WORD_RST = 32'h00000000;
   // Bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef struct packed {
      logic debug_src;
      logic converter_src;
      logic mac_receive_src;
      logic mac_transmit_src;
      logic mac_timer_src;
      logic crypto_src;
      logic serial_two_src;
      logic serial_one_src;
      logic sleep_timer_src;
      logic baseband_src;
      logic management_src;
      logic timer_two_src;
      logic timer_one_src;
   } onchip_src_t;

   typedef struct packed {
      logic [16:0] enter;
      logic [16:0] leave;
   } core_service_t;

   typedef struct packed {
      logic valid;
      logic bad_access_width_fault;
      logic privilege_fault;
      logic unimpl_addr_fault;
   } bus_fault_t;

   typedef struct packed {
      logic [31:0] addr;
      logic write;
      logic word;
   } ahb_dphase_t;
endpackage

// ---- verilog/pin_edge_sync.sv ----
// Two-flop synchroniser and rising-edge detector for the external interrupt pins
`timescale 1ns/1ps
module pin_edge_sync #(
   parameter int W = 4
) (
   // Clock and reset
   input logic hclk,
   input logic hresetn,
   // Pins and edge pulses
   input logic [W-1:0] pin_in,
   output logic [W-1:0] rise
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;
   logic [W-1:0] last_reg;

   // Only sync_reg reads meta_reg
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_reg <= '0;
         sync_reg <= '0;
         last_reg <= '0;
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign rise = sync_reg & ~last_reg;
endmodule

// ---- verilog/aux_fault_flags.sv ----
// Auxiliary bus fault status flags with overflow tracking
`timescale 1ns/1ps
module aux_fault_flags
   import irq_book_pkg::*;
(
   // Clock and reset
   input logic hclk,
   input logic hresetn,
   // Fault report
   input bus_fault_t fault,
   // Software write
   input logic wr_en,
   input logic [AUX_FAULT_BITS-1:0] wr_data,
   // Flags
   output logic [AUX_FAULT_BITS-1:0] flags,
   output logic new_fault
);
   logic [AUX_FAULT_BITS-1:0] flags_reg;
   logic [AUX_FAULT_BITS-1:0] set_vec;

   assign new_fault = fault.valid && (fault.bad_access_width_fault ||
      fault.privilege_fault || fault.unimpl_addr_fault);

   always_comb begin
      set_vec = '0;
      set_vec[FAULT_WIDTH_BIT] = fault.valid && fault.bad_access_width_fault;
      set_vec[FAULT_PRIV_BIT] = fault.valid && fault.privilege_fault;
      set_vec[FAULT_UNIMPL_BIT] = fault.valid && fault.unimpl_addr_fault;
      set_vec[FAULT_OVERFLOW_BIT] = new_fault && (flags_reg != '0);
   end

   // Hardware set wins over a software write in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_reg <= AUX_FAULT_RST;
      end else begin
         flags_reg <= (wr_en ? wr_data : flags_reg) | set_vec;
      end
   end

   assign flags = flags_reg;

   a_width_flag: assert property (
      @(posedge hclk) disable iff (!hresetn)
      fault.valid && fault.bad_access_width_fault |=> flags_reg[FAULT_WIDTH_BIT])
      else $error("wrong-size fault not recorded");
   a_priv_flag: assert property (
      @(posedge hclk) disable iff (!hresetn)
      fault.valid && fault.privilege_fault |=> flags_reg[FAULT_PRIV_BIT])
      else $error("privilege fault not recorded");
   a_unimpl_flag: assert property (
      @(posedge hclk) disable iff (!hresetn)
      fault.valid && fault.unimpl_addr_fault |=> flags_reg[FAULT_UNIMPL_BIT])
      else $error("unimplemented-address fault not recorded");
   a_overflow_flag: assert property (
      @(posedge hclk) disable iff (!hresetn)
      new_fault && (flags_reg != '0) |=> flags_reg[FAULT_OVERFLOW_BIT])
      else $error("overflow fault not recorded");
   a_flags_hold: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !wr_en && !fault.valid |=> $stable(flags_reg))
      else $error("fault flags changed without cause");
endmodule

// ---- verilog/interrupt_pending_status_regs.sv ----
// Interrupt pending, enable, active and missed bookkeeping with an AHB-Lite register slave
//
// Behaviour
// - Pending-clear write one unpends that source
// - Fixed source bit positions, debug at 16
// - Read-only active register tracks serviced sources
// - Missed flags only in bits 2-15
// - Byte, halfword or unaligned access: width fault
// - Unprivileged protected write: privilege fault
// - Unimplemented address access: unimplemented fault
// - Fault while flags set: overflow fault
// - Pending-set write one makes source pending
// - Enable-clear write one disables that source
`timescale 1ns/1ps
module interrupt_pending_status_regs
   import irq_book_pkg::*;
(
   // Clock and reset
   input logic hclk,
   input logic hresetn,
   // AHB-Lite slave
   input logic hsel,
   input logic [31:0] haddr,
   input logic [1:0] htrans,
   input logic hwrite,
   input logic [2:0] hsize,
   input logic hready,
   input logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Interrupt sources
   input onchip_src_t onchip_src,
   input logic [EXT_PINS-1:0] ext_pin_in,
   // Core side
   input core_service_t core_service,
   input bus_fault_t bus_fault,
   output logic [NUM_SRC-1:0] irq_request,
   output logic irq
);
   // Bus data phase state
   ahb_dphase_t dphase_reg;
   logic [31:0] hrdata_reg;
   logic hreadyout_reg;
   logic hresp_reg;
   logic addr_phase;

   // Bookkeeping state
   logic [NUM_SRC-1:0] pending_reg;
   logic [NUM_SRC-1:0] pending_next;
   logic [NUM_SRC-1:0] enable_reg;
   logic [NUM_SRC-1:0] enable_next;
   logic [NUM_SRC-1:0] active_reg;
   logic [NUM_SRC-1:0] active_next;
   logic [NUM_SRC-1:0] missed_reg;
   logic [NUM_SRC-1:0] missed_next;
   logic [IST_BITS-1:0] ist_reg;
   logic [IST_BITS-1:0] ist_next;
   logic [IST_BITS-1:0] mask_reg;
   logic [NUM_SRC-1:0] irq_request_reg;
   logic irq_reg;

   // Event and write decode
   logic [EXT_PINS-1:0] ext_rise;
   logic [NUM_SRC-1:0] ev_vec;
   logic [NUM_SRC-1:0] miss_set;
   logic [NUM_SRC-1:0] wdata_src;
   logic [IST_BITS-1:0] ist_set;
   logic [AUX_FAULT_BITS-1:0] aux_flags;
   logic aux_new_fault;
   logic wr_enable_set;
   logic wr_enable_clear;
   logic wr_pending_set;
   logic wr_pending_clear;
   logic wr_missed;
   logic wr_ist;
   logic wr_mask;
   logic wr_aux;
   logic wr_active;
   logic [31:0] rd_word;

   // Write strobe for one register in the data phase; sub-word writes never match
   function automatic logic wr_hit(input ahb_dphase_t p, input logic [31:0] a);
      return p.write && p.word && (p.addr == a);
   endfunction

   function automatic logic [31:0] widen_src(input logic [NUM_SRC-1:0] v);
      return {{(32 - NUM_SRC){1'b0}}, v};
   endfunction

   // AHB-Lite address phase capture
   assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dphase_reg <= '0;
      end else if (hready) begin
         dphase_reg.addr <= haddr;
         dphase_reg.write <= addr_phase && hwrite;
         dphase_reg.word <= (hsize == HSIZE_WORD);
      end
   end

   // Zero wait states: the slave never stretches a transfer and always answers OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
      end else begin
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
      end
   end

   assign wdata_src = hwdata[NUM_SRC-1:0];
   assign wr_enable_set = wr_hit(dphase_reg, ENABLE_SET_ADDR);
   assign wr_enable_clear = wr_hit(dphase_reg, ENABLE_CLEAR_ADDR);
   assign wr_pending_set = wr_hit(dphase_reg, PENDING_SET_ADDR);
   assign wr_pending_clear = wr_hit(dphase_reg, PENDING_CLEAR_ADDR);
   assign wr_missed = wr_hit(dphase_reg, MISSED_ADDR);
   assign wr_ist = wr_hit(dphase_reg, IRQ_STATUS_ADDR);
   assign wr_mask = wr_hit(dphase_reg, IRQ_MASK_ADDR);
   assign wr_aux = wr_hit(dphase_reg, AUX_FAULT_ADDR);
   // Decoded only so the read-only behaviour can be checked; nothing acts on it
   assign wr_active = wr_hit(dphase_reg, ACTIVE_ADDR);

   // Read mux; unmapped addresses read as zero
   always_comb begin
      unique case (haddr)
         ENABLE_SET_ADDR: rd_word = widen_src(enable_reg);
         ENABLE_CLEAR_ADDR: rd_word = widen_src(enable_reg);
         PENDING_SET_ADDR: rd_word = widen_src(pending_reg);
         PENDING_CLEAR_ADDR: rd_word = widen_src(pending_reg);
         ACTIVE_ADDR: rd_word = widen_src(active_reg);
         MISSED_ADDR: rd_word = widen_src(missed_reg & MISSED_MASK);
         IRQ_STATUS_ADDR: rd_word = {{(32 - IST_BITS){1'b0}}, ist_reg};
         IRQ_MASK_ADDR: rd_word = {{(32 - IST_BITS){1'b0}}, mask_reg};
         AUX_FAULT_ADDR: rd_word = {{(32 - AUX_FAULT_BITS){1'b0}}, aux_flags};
         default: rd_word = WORD_RST;
      endcase
   end

   // Read data is sampled at the address phase, so a read right after a write
   // to the same register returns the value before that write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= WORD_RST;
      end else if (hready) begin
         hrdata_reg <= (addr_phase && !hwrite) ? rd_word : WORD_RST;
      end
   end

   // Source vector assembly
   pin_edge_sync #(
      .W(EXT_PINS)
   ) u_pin_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_in(ext_pin_in),
      .rise(ext_rise)
   );

   assign ev_vec = {onchip_src.debug_src, ext_rise, onchip_src[11:0]};

   // Pending state: source events and set writes win over clears
   always_comb begin
      pending_next = pending_reg;
      if (wr_pending_clear) begin
         pending_next = pending_next & ~wdata_src;
      end
      pending_next = pending_next & ~core_service.enter;
      if (wr_pending_set) begin
         pending_next = pending_next | wdata_src;
      end
      pending_next = pending_next | ev_vec;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pending_reg <= SRC_VEC_RST;
      end else begin
         pending_reg <= pending_next;
      end
   end

   // Enable state
   always_comb begin
      enable_next = enable_reg;
      if (wr_enable_set) begin
         enable_next = enable_next | wdata_src;
      end
      if (wr_enable_clear) begin
         enable_next = enable_next & ~wdata_src;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enable_reg <= SRC_VEC_RST;
      end else begin
         enable_reg <= enable_next;
      end
   end

   // Active state follows the core's service entry and exit
   assign active_next = (active_reg & ~core_service.leave) | core_service.enter;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         active_reg <= SRC_VEC_RST;
      end else begin
         active_reg <= active_next;
      end
   end

   // Missed events: a new event on a source that is still pending
   assign miss_set = ev_vec & pending_reg & MISSED_MASK;

   always_comb begin
      missed_next = missed_reg;
      if (wr_missed) begin
         missed_next = wdata_src;
      end
      missed_next = (missed_next | miss_set) & MISSED_MASK;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         missed_reg <= SRC_VEC_RST;
      end else begin
         missed_reg <= missed_next;
      end
   end

   // Auxiliary bus fault flags
   aux_fault_flags u_aux_fault (
      .hclk(hclk),
      .hresetn(hresetn),
      .fault(bus_fault),
      .wr_en(wr_aux),
      .wr_data(hwdata[AUX_FAULT_BITS-1:0]),
      .flags(aux_flags),
      .new_fault(aux_new_fault)
   );

   // Block interrupt: sticky status, write one to clear, set wins
   always_comb begin
      ist_set = IST_RST;
      ist_set[IST_FAULT_BIT] = aux_new_fault;
      ist_set[IST_MISSED_BIT] = |miss_set;
      ist_next = ist_reg;
      if (wr_ist) begin
         ist_next = ist_next & ~hwdata[IST_BITS-1:0];
      end
      ist_next = ist_next | ist_set;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ist_reg <= IST_RST;
      end else begin
         ist_reg <= ist_next;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_reg <= IST_RST;
      end else if (wr_mask) begin
         mask_reg <= hwdata[IST_BITS-1:0];
      end
   end

   // Outputs are registered from the next-state values, except that irq uses the current mask_reg, so a mask write reaches irq a cycle later
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_reg <= 1'b0;
         irq_request_reg <= SRC_VEC_RST;
      end else begin
         irq_reg <= |(ist_next & mask_reg);
         irq_request_reg <= pending_next & enable_next;
      end
   end

   assign hrdata = hrdata_reg;
   assign hreadyout = hreadyout_reg;
   assign hresp = hresp_reg;
   assign irq = irq_reg;
   assign irq_request = irq_request_reg;

   a_pend_clear: assert property (
      @(posedge hclk) disable iff (!hresetn)
      wr_pending_clear |=> (pending_reg & $past(wdata_src) & ~$past(ev_vec)) == '0)
      else $error("pending bit survived a clear write");
   a_pin_position: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ext_rise != '0 |=> (pending_reg[15:12] & $past(ext_rise)) == $past(ext_rise))
      else $error("pin event not pending at its bit");
   a_active_track: assert property (
      @(posedge hclk) disable iff (!hresetn)
      core_service.enter != '0 && !wr_pending_set |=> ((active_reg & $past(core_service.enter)) ==
         $past(core_service.enter)) && ((pending_reg & $past(core_service.enter) &
         ~$past(ev_vec)) == '0))
      else $error("serviced source not marked active");
   a_missed_zero: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (missed_reg & ~MISSED_MASK) == '0)
      else $error("missed flag outside bits 2-15");
   a_missed_set: assert property (
      @(posedge hclk) disable iff (!hresetn)
      miss_set != '0 |=> ((missed_reg & $past(miss_set)) == $past(miss_set)) && ist_reg[IST_MISSED_BIT])
      else $error("missed event not recorded");
   a_pend_set: assert property (
      @(posedge hclk) disable iff (!hresetn)
      wr_pending_set |=> (pending_reg & $past(wdata_src)) == $past(wdata_src))
      else $error("pending-set write did not pend");
   a_enable_clear: assert property (
      @(posedge hclk) disable iff (!hresetn)
      wr_enable_clear |=> ((enable_reg | irq_request) & $past(wdata_src)) == '0)
      else $error("enable-clear write left source enabled");
   a_irq_level: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ##1 irq == |(ist_reg & $past(mask_reg)))
      else $error("interrupt output disagrees with status");
   a_pend_keep: assert property (
      @(posedge hclk) disable iff (!hresetn)
      wr_pending_clear && core_service.enter == '0 && ev_vec == '0 |=>
         (pending_reg & ~$past(wdata_src)) == ($past(pending_reg) & ~$past(wdata_src)))
      else $error("pending-clear write disturbed other sources");
   a_event_pend: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ev_vec != '0 |=> (pending_reg & $past(ev_vec)) == $past(ev_vec))
      else $error("source event not pending at its bit");
   a_active_ro: assert property (
      @(posedge hclk) disable iff (!hresetn)
      wr_active && core_service == '0 |=> $stable(active_reg))
      else $error("write changed the active register");
   a_enable_keep: assert property (
      @(posedge hclk) disable iff (!hresetn)
      wr_enable_clear |=> (enable_reg & ~$past(wdata_src)) ==
         ($past(enable_reg) & ~$past(wdata_src)))
      else $error("enable-clear write disturbed other sources");
   a_request_pend: assert property (
      @(posedge hclk) disable iff (!hresetn)
      wr_pending_set |=> (irq_request & $past(wdata_src & enable_next)) ==
         $past(wdata_src & enable_next))
      else $error("pended source not requested");
endmodule

// ---- bench/irq_source_model.sv ----
// Behavioural model of the interrupt sources and the core facing the block
`timescale 1ns/1ps
module irq_source_model
   import irq_book_pkg::*;
(
   // Clock
   input logic hclk,
   // Source, pin and core lines
   output onchip_src_t onchip_src,
   output logic [EXT_PINS-1:0] ext_pin_in,
   output core_service_t core_service,
   output bus_fault_t bus_fault
);
   initial begin
      onchip_src = '0;
      ext_pin_in = '0;
      core_service = '0;
      bus_fault = '0;
   end

   // One-cycle pulses in the block's clock, launched just after a rising edge
   task automatic pulse(input onchip_src_t s, input core_service_t c, input bus_fault_t f);
      onchip_src <= s;
      core_service <= c;
      bus_fault <= f;
      @(posedge hclk);
      onchip_src <= '0;
      core_service <= '0;
      bus_fault <= '0;
   endtask

   // Pins held past the synchroniser latency so the edge is never lost
   task automatic pin_edge(input logic [EXT_PINS-1:0] p);
      ext_pin_in <= p;
      repeat (6) @(posedge hclk);
      ext_pin_in <= '0;
   endtask
endmodule

// ---- bench/interrupt_pending_status_regs_tb_top.sv ----
// Self-checking bench driving the interrupt bookkeeping block over AHB-Lite
`timescale 1ns/1ps
module interrupt_pending_status_regs_tb_top;
   import irq_book_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, rdat;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [NUM_SRC-1:0] irq_request;
   onchip_src_t onchip_src;
   logic [EXT_PINS-1:0] ext_pin_in;
   core_service_t core_service;
   bus_fault_t bus_fault;
   int bad_count, comparisons;
   localparam logic [31:0] UNMAPPED_ADDR = 32'h4000A860;

   interrupt_pending_status_regs dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .onchip_src(onchip_src),
      .ext_pin_in(ext_pin_in), .core_service(core_service), .bus_fault(bus_fault),
      .irq_request(irq_request), .irq(irq)
   );

   irq_source_model src (
      .hclk(hclk), .onchip_src(onchip_src), .ext_pin_in(ext_pin_in),
      .core_service(core_service), .bus_fault(bus_fault)
   );

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   task automatic final_report();
      if (bad_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Bounded wait for hready at a rising edge; outputs read here are pre-edge values
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         bad_count++;
         final_report();
      end
   endtask

   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [2:0] sz);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= sz;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      rdat = hrdata;
      check("hresp", {31'h0, hresp}, 32'h0);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d,
                     input logic [2:0] sz = HSIZE_WORD);
      xfer(1'b1, a, d, sz);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      xfer(1'b0, a, WORD_RST, HSIZE_WORD);
      check($sformatf("reg %h", a), rdat, e);
   endtask

   // Two edges let a register update reach the registered outputs
   task automatic outs(input logic [NUM_SRC-1:0] req, input logic ir);
      repeat (2) @(posedge hclk);
      check("irq_request", {15'h0, irq_request}, {15'h0, req});
      check("irq", {31'h0, irq}, {31'h0, ir});
   endtask

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = WORD_RST;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = HSIZE_WORD;
      hwdata = WORD_RST;
      bad_count = 0;
      comparisons = 0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd(MISSED_ADDR, WORD_RST);
      rd(PENDING_CLEAR_ADDR, WORD_RST);
      rd(ACTIVE_ADDR, WORD_RST);
      rd(AUX_FAULT_ADDR, WORD_RST);
      outs('0, 1'b0);
      wr(ENABLE_SET_ADDR, 32'h0001FFFF);
      src.pulse(onchip_src_t'(13'h1FFF), '0, '0);
      rd(PENDING_SET_ADDR, 32'h00010FFF);
      src.pin_edge(4'h2);
      rd(PENDING_SET_ADDR, 32'h00012FFF);
      src.pin_edge(4'hD);
      outs(17'h1FFFF, 1'b0);
      wr(PENDING_CLEAR_ADDR, 32'h00010005);
      rd(PENDING_CLEAR_ADDR, 32'h0000FFFA);
      wr(PENDING_CLEAR_ADDR, WORD_RST);
      rd(PENDING_CLEAR_ADDR, 32'h0000FFFA);
      outs(17'h0FFFA, 1'b0);
      // Timer bit 1 is pending too but has no missed flag
      src.pulse(onchip_src_t'(13'h1FFF), '0, '0);
      rd(MISSED_ADDR, 32'h00000FF8);
      src.pin_edge(4'h1);
      rd(MISSED_ADDR, 32'h00001FF8);
      wr(MISSED_ADDR, 32'hFFFFFFFF);
      rd(MISSED_ADDR, {15'h0, MISSED_MASK});
      wr(MISSED_ADDR, WORD_RST, 3'h0);
      rd(MISSED_ADDR, {15'h0, MISSED_MASK});
      wr(MISSED_ADDR, WORD_RST);
      rd(MISSED_ADDR, WORD_RST);
      wr(PENDING_CLEAR_ADDR, 32'hFFFFFFFF);
      rd(PENDING_SET_ADDR, WORD_RST);
      wr(PENDING_SET_ADDR, 32'h00010001);
      rd(PENDING_SET_ADDR, 32'h00010001);
      wr(PENDING_SET_ADDR, WORD_RST);
      rd(PENDING_SET_ADDR, 32'h00010001);
      wr(ENABLE_CLEAR_ADDR, 32'h00000001);
      wr(ENABLE_CLEAR_ADDR, WORD_RST);
      rd(ENABLE_SET_ADDR, 32'h0001FFFE);
      outs(17'h10000, 1'b0);
      src.pulse('0, core_service_t'({17'h10000, 17'h0}), '0);
      rd(ACTIVE_ADDR, 32'h00010000);
      rd(PENDING_SET_ADDR, 32'h00000001);
      wr(ACTIVE_ADDR, WORD_RST);
      rd(ACTIVE_ADDR, 32'h00010000);
      src.pulse('0, core_service_t'({17'h0, 17'h10000}), '0);
      rd(ACTIVE_ADDR, WORD_RST);
      wr(IRQ_MASK_ADDR, 32'h00000001);
      src.pulse('0, '0, bus_fault_t'(4'hC));
      rd(AUX_FAULT_ADDR, 32'h00000008);
      outs('0, 1'b1);
      rd(IRQ_STATUS_ADDR, 32'h00000003);
      wr(IRQ_MASK_ADDR, 32'h00000002);
      outs('0, 1'b1);
      repeat (10) @(posedge hclk);
      rd(AUX_FAULT_ADDR, 32'h00000008);
      src.pulse('0, '0, bus_fault_t'(4'hA));
      rd(AUX_FAULT_ADDR, 32'h0000000D);
      wr(AUX_FAULT_ADDR, WORD_RST);
      rd(AUX_FAULT_ADDR, WORD_RST);
      src.pulse('0, '0, bus_fault_t'(4'h9));
      rd(AUX_FAULT_ADDR, 32'h00000002);
      wr(IRQ_STATUS_ADDR, 32'h00000003);
      outs('0, 1'b0);
      // Mid-run reset with fault and pending state still set
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd(AUX_FAULT_ADDR, WORD_RST);
      rd(PENDING_CLEAR_ADDR, WORD_RST);
      rd(UNMAPPED_ADDR, WORD_RST);
      final_report();
   end
endmodule
